// file: logic/cts_pkg.sv
// constants and types for the capture trigger and sync block
package cts_pkg;
   localparam int unsigned CLK_FREQ_MHZ   = 25;
   localparam int unsigned CLK_PERIOD_NS  = 1000 / CLK_FREQ_MHZ;
   localparam int unsigned OUT_LAT_MIN_NS = 50;
   localparam int unsigned OUT_LAT_MAX_NS = 75;
   // least latency rounds up: 50 ns -> 2 cycles, counted from the match cycle
   localparam int unsigned OUT_LAT_CYC    = (OUT_LAT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PULSE_NS       = 24;
   localparam int unsigned PULSE_OLD_NS   = 40;
   localparam int unsigned PULSE_CYC_RAW  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PULSE_CYC      = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
   localparam int unsigned PULSE_OLD_CYC  = (PULSE_OLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned NUM_LEG_IN     = 4;
   localparam int unsigned NUM_SRC        = 11;
   localparam int unsigned THROTTLE_CYC   = 4;
   // avalon byte addresses
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_SRC_SEL = 4'h4;
   localparam logic [3:0] ADDR_LEG_CFG = 4'h8;
   localparam logic [3:0] ADDR_STATUS  = 4'hc;
   // control field positions
   localparam int unsigned CTRL_ARM        = 0;
   localparam int unsigned CTRL_STOP       = 1;
   localparam int unsigned CTRL_IGN_TRIG   = 2;
   localparam int unsigned CTRL_IGN_STOP   = 3;
   localparam int unsigned CTRL_RELEASE    = 4;
   localparam int unsigned CTRL_OUT_EVERY  = 5;
   localparam int unsigned CTRL_OLD_PULSE  = 6;
   localparam int unsigned CTRL_MODE_LSB   = 8;
   localparam logic [31:0] CTRL_RESET      = 32'h0;
   // capture stream symbols, 9 bits: k flag and byte
   localparam logic [8:0] UNDERRUN_FILL_SYMBOL = 9'h17c;
   localparam logic [8:0] SUBST_SYMBOL         = 9'h19c;
   typedef enum logic [1:0]
   {
      CTS_OUT_LOW  = 2'b00,
      CTS_OUT_HIGH = 2'b01,
      CTS_OUT_PPUL = 2'b10,
      CTS_OUT_NPUL = 2'b11
   } cts_out_mode_t;
   typedef enum logic [2:0]
   {
      CTS_IDLE    = 3'b000,
      CTS_WAIT    = 3'b001,
      CTS_PRE     = 3'b010,
      CTS_POST    = 3'b011,
      CTS_STOPPED = 3'b100
   } cts_state_t;
endpackage

// file: logic/cts_trigger_sync.sv
// capture trigger, chain sync, external i/o and simple matching
// ============================================================
// How it works
// - after trigger, external input edges become events
// - fast input sampled; events throttled when too dense
// - legacy inputs: monitor enable, rise/fall/both trigger
// - legacy trigger works with monitoring disabled
// - external output follows match 2 cycles (80 ns) later; latency window is 50..75 ns
// - output low, high, positive or negative pulse
// - share timestamp; pass start, trigger, stop along chain
// - capture starts once the upstream neighbour reports ready
// - own trigger sends chain trigger
// - ignore incoming trigger, still send own
// - own stop sends chain stop; received stop stops
// - ignore incoming stop, still send own
// - release: no wait, ignore chain trigger and stop
// - superspeed matcher separate from legacy matcher
// - selectable simple match sources
// - phy errors combine into one source
// - underrun inserts fill symbol
// - decode error records substitute symbol
// - first selected match triggers, only once
// - output once at own trigger (not a chain trigger) or every match
// - single-state complex matcher, limited resources
`default_nettype none
module cts_trigger_sync
   import cts_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire logic [3:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   input  wire logic                  ext_in,
   input  wire logic [NUM_LEG_IN-1:0] leg_in,
   input  wire logic                  sync_in_ready,
   input  wire logic                  sync_in_trig,
   input  wire logic                  sync_in_stop,
   input  wire logic                  sync_in_ts_clr,
   output logic                       sync_out_ready,
   output logic                       sync_out_trig,
   output logic                       sync_out_stop,
   output logic                       sync_out_ts_clr,
   input  wire logic [NUM_SRC-1:0]    ss_src,
   input  wire logic                  phy_disp_err,
   input  wire logic                  phy_eb_under,
   input  wire logic                  phy_eb_over,
   input  wire logic                  phy_dec_err,
   input  wire logic [8:0]            sym_in,
   input  wire logic                  sym_in_vld,
   input  wire logic                  cm_match,
   output logic [8:0]                 sym_out,
   output logic                       sym_out_vld,
   output logic                       evt_vld,
   output logic [4:0]                 evt_lines,
   output logic [31:0]                timestamp,
   output logic                       ext_out
);
   typedef struct packed
   {
      logic [31:0]           ctrl;
      logic [NUM_SRC-1:0]    src_sel;
      logic [11:0]           leg_cfg;
      logic [1:0]            rd_phase;
      logic [31:0]           rdata;
      logic [1:0]            ext_s;
      logic [2*NUM_LEG_IN-1:0] leg_s;
      logic [NUM_LEG_IN:0]   prev;
      logic [7:0]            sy_s;
      logic [3:0]            sy_q;
      cts_state_t            st;
      logic [2:0]            thr;
      logic [3:0]            lat;
      logic [3:0]            pw;
      logic                  lvl;
      logic                  started;
      logic [31:0]           ts;
      logic                  s_rdy;
      logic                  s_trg;
      logic                  s_stp;
      logic                  s_tsc;
      logic [8:0]            sym;
      logic                  sym_v;
      logic                  ev_v;
      logic [4:0]            ev_l;
      logic                  eo;
   } cts_regs_t;
   cts_regs_t r, n;
   function automatic logic edge_hit(input logic cur, input logic old, input logic [1:0] sel);
      edge_hit = (sel[0] & cur & ~old) | (sel[1] & ~cur & old);
   endfunction
   logic                  ext_q, rdy_q, trg_q, stp_q, tsc_q;
   logic [NUM_LEG_IN-1:0] leg_q;
   logic                  own_trig, own_stop, chain_trig, chain_stop, phy_err;
   logic [NUM_SRC:0]      srcs;
   logic                  any_match, ext_rise, ext_fall, rel;
   logic [NUM_LEG_IN-1:0] leg_mon;
   logic [3:0]            pw_len;
   cts_out_mode_t         omode;
   always_comb
   begin
      n        = r;
      // second stage of each synchroniser
      ext_q    = r.ext_s[1];
      leg_q    = r.leg_s[2*NUM_LEG_IN-1:NUM_LEG_IN];
      rdy_q    = r.sy_s[4];
      trg_q    = r.sy_s[5];
      stp_q    = r.sy_s[6];
      tsc_q    = r.sy_s[7];
      rel      = r.ctrl[CTRL_RELEASE];
      omode    = cts_out_mode_t'(r.ctrl[CTRL_MODE_LSB +: 2]);
      leg_mon  = r.leg_cfg[NUM_LEG_IN-1:0];
      ext_rise = ext_q & ~r.prev[NUM_LEG_IN];
      ext_fall = ~ext_q & r.prev[NUM_LEG_IN];
      // phy errors fold into one source
      phy_err  = phy_disp_err | phy_eb_under | phy_eb_over | phy_dec_err;
      // superspeed sources only; legacy trigger is its own path
      srcs     = {phy_err, ss_src} & {1'b1, r.src_sel};
      any_match = (|srcs) | cm_match;
      for (int i = 0; i < NUM_LEG_IN; i++)
      begin
         // trigger does not depend on the monitor enable
         if (edge_hit(leg_q[i], r.prev[i], r.leg_cfg[NUM_LEG_IN+2*i +: 2]))
            any_match = 1'b1;
      end
      own_trig   = (r.st == CTS_PRE) && any_match;
      chain_trig = (r.st == CTS_PRE) && trg_q && !r.sy_q[1]
                   && !r.ctrl[CTRL_IGN_TRIG] && !rel;
      chain_stop = stp_q && !r.sy_q[2] && !r.ctrl[CTRL_IGN_STOP] && !rel;
      own_stop   = ((r.st == CTS_PRE) || (r.st == CTS_POST)) && r.ctrl[CTRL_STOP];
      n.prev     = {ext_q, leg_q};
      n.ext_s    = {r.ext_s[0], ext_in};
      n.leg_s    = {r.leg_s[NUM_LEG_IN-1:0], leg_in};
      n.sy_s     = {r.sy_s[3:0], sync_in_ts_clr, sync_in_stop, sync_in_trig, sync_in_ready};
      n.sy_q     = {tsc_q, stp_q, trg_q, rdy_q};
      n.ctrl[CTRL_STOP] = 1'b0;
      n.s_trg    = 1'b0;
      n.s_stp    = 1'b0;
      n.s_tsc    = 1'b0;
      n.ts       = r.ts + 32'h1;
      if (tsc_q && !r.sy_q[3])
         n.ts = 32'h0;
      // capture state machine
      case (r.st)
         CTS_IDLE:
         begin
            if (r.ctrl[CTRL_ARM])
               n.st = CTS_WAIT;
         end
         CTS_WAIT:
         begin
            // ready goes out in wait, pre and post, not passed down the chain; start when the upstream is ready too
            if (rel || rdy_q)
            begin
               n.st    = CTS_PRE;
               n.ts    = 32'h0;
               n.s_tsc = 1'b1;
            end
         end
         CTS_PRE:
         begin
            if (own_trig || chain_trig)
               n.st = CTS_POST;
            if (own_trig || chain_trig)
               n.s_trg = 1'b1;
         end
         CTS_POST:
            n.st = CTS_POST;
         CTS_STOPPED:
         begin
            if (!r.ctrl[CTRL_ARM])
               n.st = CTS_IDLE;
         end
         default:
            n.st = CTS_IDLE;
      endcase
      if ((r.st == CTS_PRE || r.st == CTS_POST) && (own_stop || chain_stop))
      begin
         n.st    = CTS_STOPPED;
         n.s_stp = own_stop;
      end
      if (!r.ctrl[CTRL_ARM])
         n.st = CTS_IDLE;
      n.s_rdy = (r.st == CTS_WAIT) || (r.st == CTS_PRE) || (r.st == CTS_POST);
      // events after trigger, throttled to one per window
      n.ev_v = 1'b0;
      if (r.thr != 3'h0)
         n.thr = r.thr - 3'h1;
      if (r.st == CTS_POST && r.thr == 3'h0)
      begin
         n.ev_l = {ext_rise | ext_fall, leg_q & leg_mon};
         for (int i = 0; i < NUM_LEG_IN; i++)
         begin
            if (leg_mon[i] && (leg_q[i] != r.prev[i]))
               n.ev_v = 1'b1;
         end
         if (ext_rise || ext_fall)
            n.ev_v = 1'b1;
         if (n.ev_v)
            n.thr = 3'(THROTTLE_CYC - 1);
      end
      // captured symbol stream
      n.sym_v = sym_in_vld | phy_eb_under;
      n.sym   = sym_in;
      if (phy_eb_under)
         n.sym = UNDERRUN_FILL_SYMBOL;
      else if (phy_dec_err)
         n.sym = SUBST_SYMBOL;
      // external output: lat counts the pipeline to 2 cycles (80 ns) from the match cycle; window is 50..75 ns
      n.lat = {r.lat[2:0], own_trig || (r.ctrl[CTRL_OUT_EVERY] && r.st == CTS_POST && any_match)};
      pw_len = r.ctrl[CTRL_OLD_PULSE] ? 4'(PULSE_OLD_CYC) : 4'(PULSE_CYC);
      if (r.pw != 4'h0)
         n.pw = r.pw - 4'h1;
      if (r.lat[OUT_LAT_CYC-2])
      begin
         n.pw  = pw_len;
         n.lvl = 1'b1;
      end
      case (omode)
         CTS_OUT_LOW:  n.eo = 1'b0;
         CTS_OUT_HIGH: n.eo = 1'b1;
         CTS_OUT_PPUL: n.eo = r.lat[OUT_LAT_CYC-2] || (r.pw > 4'h1);
         CTS_OUT_NPUL: n.eo = !(r.lat[OUT_LAT_CYC-2] || (r.pw > 4'h1));
         default:      n.eo = 1'b0;
      endcase
      // avalon slave: read answers one cycle after request
      n.rd_phase = 2'b00;
      if ((avs_read || avs_write) && r.rd_phase == 2'b00)
      begin
         n.rd_phase = 2'b01;
         case (avs_address)
            ADDR_CTRL:    n.rdata = r.ctrl;
            ADDR_SRC_SEL: n.rdata = {21'h0, r.src_sel};
            ADDR_LEG_CFG: n.rdata = {20'h0, r.leg_cfg};
            ADDR_STATUS:  n.rdata = {26'h0, r.lvl, r.s_trg, r.st, r.started};
            default:      n.rdata = 32'h0;
         endcase
      end
      // a write lands only on the edge where the master sees waitrequest low
      if (avs_write && r.rd_phase == 2'b01)
      begin
         case (avs_address)
            ADDR_CTRL:    n.ctrl    = avs_writedata;
            ADDR_SRC_SEL: n.src_sel = avs_writedata[NUM_SRC-1:0];
            ADDR_LEG_CFG: n.leg_cfg = avs_writedata[11:0];
            default:      n.ctrl    = n.ctrl;
         endcase
      end
      if (r.st == CTS_POST)
         n.started = 1'b1;
      if (r.st == CTS_IDLE)
         n.started = 1'b0;
      if (r.ctrl[CTRL_ARM] && r.st == CTS_IDLE)
         n.lvl = 1'b0;
   end
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         r      <= '0;
         r.ctrl <= CTRL_RESET;
         r.st   <= CTS_IDLE;
      end
      else
         r <= n;
   end
   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = ~r.rd_phase[0];
   assign sync_out_ready  = r.s_rdy;
   assign sync_out_trig   = r.s_trg;
   assign sync_out_stop   = r.s_stp;
   assign sync_out_ts_clr = r.s_tsc;
   assign sym_out         = r.sym;
   assign sym_out_vld     = r.sym_v;
   assign evt_vld         = r.ev_v;
   assign evt_lines       = r.ev_l;
   assign timestamp       = r.ts;
   assign ext_out         = r.eo;
   // ============================================================
   // checks
   sequence s_pre_match;
      (r.st == CTS_PRE) && any_match;
   endsequence
   AST_TRIG_ONCE: assert property (@(posedge ref_clk) disable iff (reset)
      s_pre_match |=> (r.st == CTS_POST || r.st == CTS_STOPPED || r.st == CTS_IDLE))
      else $error("match in pre-trigger did not trigger");
   AST_SEND_TRIG: assert property (@(posedge ref_clk) disable iff (reset)
      s_pre_match |=> sync_out_trig)
      else $error("own trigger not sent on chain");
   AST_IGN_TRIG: assert property (@(posedge ref_clk) disable iff (reset)
      (r.ctrl[CTRL_IGN_TRIG] && r.st == CTS_PRE && !any_match && r.ctrl[CTRL_ARM]
       && !r.ctrl[CTRL_STOP] && !chain_stop) |=> r.st == CTS_PRE)
      else $error("ignored chain trigger advanced capture");
   AST_RELEASE: assert property (@(posedge ref_clk) disable iff (reset)
      (r.st == CTS_WAIT && rel && r.ctrl[CTRL_ARM]) |=> r.st == CTS_PRE)
      else $error("released device waited on chain");
   AST_STOP_OUT: assert property (@(posedge ref_clk) disable iff (reset)
      (own_stop && r.ctrl[CTRL_ARM]) |=> (sync_out_stop && r.st == CTS_STOPPED))
      else $error("own stop not sent");
   AST_IGN_STOP: assert property (@(posedge ref_clk) disable iff (reset)
      sync_out_stop |-> $past(r.ctrl[CTRL_STOP]))
      else $error("stop sent without own stop");
   AST_FILL: assert property (@(posedge ref_clk) disable iff (reset)
      phy_eb_under |=> (sym_out == UNDERRUN_FILL_SYMBOL && sym_out_vld))
      else $error("underrun fill symbol missing");
   AST_SUBST: assert property (@(posedge ref_clk) disable iff (reset)
      (phy_dec_err && !phy_eb_under) |=> sym_out == SUBST_SYMBOL)
      else $error("substitute symbol missing");
   AST_OUT_LAT: assert property (@(posedge ref_clk) disable iff (reset)
      (own_trig && omode == CTS_OUT_PPUL) |-> ##2 ext_out)
      else $error("external output latency wrong");
   AST_EVT_PRE: assert property (@(posedge ref_clk) disable iff (reset)
      evt_vld |-> $past(r.st) == CTS_POST)
      else $error("event recorded before trigger");
   sequence s_chain_start;
      (r.st == CTS_WAIT) && (rel || rdy_q) && r.ctrl[CTRL_ARM];
   endsequence
   AST_TS_CLR_OUT: assert property (@(posedge ref_clk) disable iff (reset)
      s_chain_start |=> (sync_out_ts_clr && timestamp == 32'h0))
      else $error("capture start did not clear and share timestamp");
   AST_READY_OUT: assert property (@(posedge ref_clk) disable iff (reset)
      (r.st == CTS_IDLE) |=> !sync_out_ready)
      else $error("ready sent while idle");
   AST_LEG_TRIG: assert property (@(posedge ref_clk) disable iff (reset)
      (r.st == CTS_PRE && !leg_mon[0]
       && edge_hit(leg_q[0], r.prev[0], r.leg_cfg[NUM_LEG_IN +: 2])) |=> sync_out_trig)
      else $error("unmonitored legacy input did not trigger");
   AST_EVT_THR: assert property (@(posedge ref_clk) disable iff (reset)
      evt_vld |=> (!evt_vld) [*3])
      else $error("events not throttled");
   AST_PHY_SRC: assert property (@(posedge ref_clk) disable iff (reset)
      (r.st == CTS_PRE && (phy_disp_err || phy_eb_over)) |=> r.st != CTS_PRE)
      else $error("phy error did not match");
   AST_RX_STOP: assert property (@(posedge ref_clk) disable iff (reset)
      (r.st == CTS_POST && chain_stop && r.ctrl[CTRL_ARM]) |=> r.st == CTS_STOPPED)
      else $error("received stop did not stop capture");
   AST_IGN_STOP_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      (r.st == CTS_POST && stp_q && r.ctrl[CTRL_IGN_STOP] && !r.ctrl[CTRL_STOP]
       && r.ctrl[CTRL_ARM]) |=> r.st == CTS_POST)
      else $error("ignored chain stop ended capture");
   AST_OUT_LOW: assert property (@(posedge ref_clk) disable iff (reset)
      (omode == CTS_OUT_LOW) |=> !ext_out)
      else $error("static low output not low");
endmodule
`default_nettype wire

// file: tb/cts_chain_peer.sv
// upstream chain neighbour model: ready level, trigger, stop and timestamp clear
`default_nettype none
module cts_chain_peer
   import cts_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic reset,
   input  wire logic sync_out_trig,
   input  wire logic sync_out_stop,
   output logic      sync_in_ready,
   output logic      sync_in_trig,
   output logic      sync_in_stop,
   output logic      sync_in_ts_clr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       standby = 1'b0;
   logic [2:0] ev      = 3'b000;
   int         n_trig  = 0;
   int         n_stop  = 0;
   // ready only while this neighbour sits in its own sync standby
   assign sync_in_ready  = standby;
   assign sync_in_trig   = ev[0];
   assign sync_in_stop   = ev[1];
   assign sync_in_ts_clr = ev[2];
   // three cycles wide so a two-stage synchroniser cannot miss the edge
   task automatic send(input logic [2:0] k);
      ev <= k;
      repeat (3) @(posedge ref_clk);
      ev <= 3'b000;
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk)
   begin
      if (sync_out_trig === 1'b1)
         n_trig <= n_trig + 1;
      if (sync_out_stop === 1'b1)
         n_stop <= n_stop + 1;
   end
endmodule
`default_nettype wire

// file: tb/cts_trigger_sync_test.sv
// self-checking bench for the capture trigger and sync block
`default_nettype none
module cts_trigger_sync_test
   import cts_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  ref_clk, reset, avs_read, avs_write, avs_waitrequest, ext_in;
   logic                  sync_in_ready, sync_in_trig, sync_in_stop, sync_in_ts_clr;
   logic                  sync_out_ready, sync_out_trig, sync_out_stop, sync_out_ts_clr;
   logic                  phy_eb_under, phy_dec_err, sym_in_vld, sym_out_vld, evt_vld, ext_out;
   logic                  phy_disp_err, phy_eb_over, cm_match;
   logic [3:0]            avs_address;
   logic [31:0]           avs_writedata, avs_readdata, timestamp, q;
   logic [NUM_LEG_IN-1:0] leg_in;
   logic [NUM_SRC-1:0]    ss_src;
   logic [8:0]            sym_in, sym_out;
   logic [4:0]            evt_lines;
   int                    n_fail = 0;
   int                    samples_checked = 0;
   int                    k;
   int                    n_tsc = 0;
   localparam logic [31:0] ARM = 32'h1 << CTRL_ARM;
   localparam logic [31:0] STP = 32'h1 << CTRL_STOP;
   localparam logic [31:0] ITR = 32'h1 << CTRL_IGN_TRIG;
   localparam logic [31:0] IST = 32'h1 << CTRL_IGN_STOP;
   localparam logic [31:0] REL = 32'h1 << CTRL_RELEASE;
   localparam logic [31:0] EVR = 32'h1 << CTRL_OUT_EVERY;
   localparam logic [31:0] POS = 32'h2 << CTRL_MODE_LSB;
   localparam logic [31:0] NEG = 32'h3 << CTRL_MODE_LSB;
   cts_trigger_sync dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_in(ext_in),
      .leg_in(leg_in), .sync_in_ready(sync_in_ready), .sync_in_trig(sync_in_trig),
      .sync_in_stop(sync_in_stop), .sync_in_ts_clr(sync_in_ts_clr),
      .sync_out_ready(sync_out_ready), .sync_out_trig(sync_out_trig),
      .sync_out_stop(sync_out_stop), .sync_out_ts_clr(sync_out_ts_clr), .ss_src(ss_src),
      .phy_disp_err(phy_disp_err), .phy_eb_under(phy_eb_under), .phy_eb_over(phy_eb_over),
      .phy_dec_err(phy_dec_err), .sym_in(sym_in), .sym_in_vld(sym_in_vld),
      .cm_match(cm_match),
      .sym_out(sym_out), .sym_out_vld(sym_out_vld), .evt_vld(evt_vld),
      .evt_lines(evt_lines), .timestamp(timestamp), .ext_out(ext_out));
   cts_chain_peer peer_u (.ref_clk(ref_clk), .reset(reset), .sync_out_trig(sync_out_trig),
      .sync_out_stop(sync_out_stop), .sync_in_ready(sync_in_ready),
      .sync_in_trig(sync_in_trig), .sync_in_stop(sync_in_stop),
      .sync_in_ts_clr(sync_in_ts_clr));
   initial
   begin
      ref_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (sync_out_ts_clr === 1'b1)
         n_tsc <= n_tsc + 1;
   // ============================================================
   // bus and compare tasks
   task automatic report_and_stop();
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp)
      begin
         $display("mismatch %0t %s", $time, m);
         n_fail++;
      end
   endtask
   // holds the request until waitrequest is seen low, then lets one edge pass
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge ref_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic st(input logic [2:0] e);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk({29'h0, q[3:1]}, {29'h0, e}, "capture state");
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic match(input int i, input logic t, input logic e1, input logic e2);
      ss_src <= NUM_SRC'(1) << i;
      @(posedge ref_clk);
      ss_src <= '0;
      @(posedge ref_clk);
      chk(32'(sync_out_trig), 32'(t), "chain trigger out");
      @(posedge ref_clk);
      chk(32'(ext_out), 32'(e1), "ext out first");
      @(posedge ref_clk);
      chk(32'(ext_out), 32'(e2), "ext out second");
   endtask
   task automatic sym(input logic v, input logic de, input logic un, input logic [8:0] e);
      sym_in <= 9'h0aa;
      sym_in_vld <= v;
      phy_dec_err <= de;
      phy_eb_under <= un;
      @(posedge ref_clk);
      sym_in_vld <= 1'b0;
      phy_dec_err <= 1'b0;
      phy_eb_under <= 1'b0;
      @(posedge ref_clk);
      chk(32'({sym_out_vld, sym_out}), {22'h0, 1'b1, e}, "captured symbol");
   endtask
   // restart with release, then fire one of {cm_match, phy_eb_over, phy_disp_err}
   task automatic rearm_hit(input logic [2:0] s);
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b1, ADDR_CTRL, ARM | REL);
      wt(4);
      st(3'd2);
      {cm_match, phy_eb_over, phy_disp_err} <= s;
      @(posedge ref_clk);
      {cm_match, phy_eb_over, phy_disp_err} <= 3'b000;
      wt(2);
      st(3'd3);
   endtask
   // ============================================================
   // tests
   initial
   begin
      #(CLK_PERIOD_NS * 20000);
      n_fail++;
      report_and_stop();
   end
   initial
   begin
      reset = 1'b1;
      {avs_read, avs_write, ext_in, phy_eb_under, phy_dec_err, sym_in_vld} = '0;
      {phy_disp_err, phy_eb_over, cm_match} = '0;
      {avs_address, avs_writedata, leg_in, ss_src, sym_in} = '0;
      wt(3);
      reset <= 1'b0;
      wt(1);
      bus(1'b0, ADDR_CTRL, 32'h0);
      chk(q, CTRL_RESET, "ctrl reset");
      st(3'd0);
      bus(1'b1, 4'h2, 32'hffffffff);
      bus(1'b0, 4'h2, 32'h0);
      chk(q, 32'h0, "unmapped read");
      bus(1'b1, ADDR_SRC_SEL, 32'h1);
      bus(1'b1, ADDR_CTRL, ARM | POS);
      wt(20);
      st(3'd1);
      chk(32'(sync_out_ready), 32'h1, "ready out");
      peer_u.standby <= 1'b1;
      wt(8);
      st(3'd2);
      match(1, 1'b0, 1'b0, 1'b0);
      match(0, 1'b1, 1'b1, 1'b0);
      st(3'd3);
      chk(q & 32'h21, 32'h21, "trigger and output flags");
      chk(32'(peer_u.n_trig), 32'h1, "one chain trigger");
      match(0, 1'b0, 1'b0, 1'b0);
      bus(1'b1, ADDR_CTRL, ARM | POS | EVR);
      match(0, 1'b0, 1'b1, 1'b0);
      k = 0;
      for (int i = 0; i < 24; i++)
      begin
         if (i < 16)
            ext_in <= ~ext_in;
         @(posedge ref_clk);
         if (evt_vld === 1'b1 && evt_lines[4] === 1'b1)
            k++;
      end
      chk(32'(k), 32'(16 / THROTTLE_CYC), "event count");
      peer_u.send(3'b100);
      wt(2);
      chk(32'(timestamp < 32'd12), 32'h1, "timestamp cleared");
      bus(1'b1, ADDR_CTRL, ARM | STP);
      wt(4);
      st(3'd4);
      chk(32'(peer_u.n_stop), 32'h1, "chain stop out");
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b1, ADDR_CTRL, ARM | ITR);
      wt(8);
      peer_u.send(3'b001);
      wt(6);
      st(3'd2);
      match(0, 1'b1, 1'b0, 1'b0);
      bus(1'b1, ADDR_CTRL, ARM | ITR | IST);
      peer_u.send(3'b010);
      wt(6);
      st(3'd3);
      bus(1'b1, ADDR_CTRL, ARM);
      peer_u.send(3'b010);
      wt(6);
      st(3'd4);
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b1, ADDR_CTRL, ARM);
      wt(8);
      peer_u.send(3'b001);
      wt(6);
      st(3'd3);
      peer_u.standby <= 1'b0;
      bus(1'b1, ADDR_CTRL, 32'h0);
      bus(1'b1, ADDR_LEG_CFG, 32'h20);
      bus(1'b1, ADDR_CTRL, ARM | REL);
      wt(8);
      st(3'd2);
      peer_u.send(3'b011);
      wt(6);
      st(3'd2);
      leg_in[0] <= 1'b1;
      wt(8);
      st(3'd2);
      leg_in[0] <= 1'b0;
      wt(8);
      st(3'd3);
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, ADDR_CTRL, 32'(m) << CTRL_MODE_LSB);
         wt(2);
         chk(32'(ext_out), 32'(m == 1 || m == 3), "static output level");
      end
      bus(1'b1, ADDR_CTRL, ARM | REL | NEG);
      wt(8);
      match(0, 1'b1, 1'b0, 1'b1);
      sym(1'b1, 1'b0, 1'b0, 9'h0aa);
      sym(1'b1, 1'b1, 1'b0, SUBST_SYMBOL);
      sym(1'b0, 1'b0, 1'b1, UNDERRUN_FILL_SYMBOL);
      rearm_hit(3'b001);
      rearm_hit(3'b010);
      rearm_hit(3'b100);
      chk(32'(n_tsc), 32'd8, "timestamp clear at each start");
      report_and_stop();
   end
endmodule
`default_nettype wire
